// ===== inc/usb_prot_pkg.sv
package usb_prot_pkg;
  // Upper five bits of the bus address
  localparam logic [4:0] DEV_ADDR_HI     = 5'h1a;
  // Register indices
  localparam logic [3:0] REG_STATUS      = 4'h0;
  localparam logic [3:0] REG_CONFIG      = 4'h1;
  localparam logic [3:0] REG_CHG_CTRL    = 4'h2;
  localparam logic [3:0] REG_CHG_STAT    = 4'h3;
  // Reset values and unmapped register read data
  localparam logic [7:0] CONFIG_RESET    = 8'h20;
  localparam logic [7:0] CHG_CTRL_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA   = 8'hff;
  // Configuration field positions
  localparam int CFG_PASS_EN     = 0;
  localparam int CFG_CL_EN       = 1;
  localparam int CFG_OVERRIDE    = 2;
  localparam int CFG_CL_OVERRIDE = 3;
  localparam int CFG_PATH_ONE    = 5;
  localparam int CFG_PATH_TWO    = 6;
  localparam int CFG_SOFT_POR    = 7;
  // Charger control field positions
  localparam int CHG_SE_RX       = 0;
  localparam int CHG_VDAT_SRC    = 2;
  localparam int CHG_HOST_SWAP   = 3;
  localparam int CHG_IDAT_SINK   = 4;
  localparam int CHG_HOST_CTRL   = 7;
  // Detected port class codes
  localparam logic [2:0] CLS_NONE   = 3'h0;
  localparam logic [2:0] CLS_DCP    = 3'h1;
  localparam logic [2:0] CLS_CDP    = 3'h2;
  localparam logic [2:0] CLS_SDP    = 3'h3;
  localparam logic [2:0] CLS_SE1_LO = 3'h4;
  localparam logic [2:0] CLS_SE1_HI = 3'h5;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_INT_NS      = 1000000;
  localparam int T_DET_NS      = 80000000;
  // State types
  typedef enum logic [1:0] {DET_IDLE, DET_PRIMARY, DET_SECONDARY, DET_DONE} det_state_t;
  typedef enum logic [2:0] {I2C_IDLE, I2C_DEV, I2C_REG, I2C_WDATA, I2C_ACK, I2C_RDATA, I2C_RACK} i2c_state_t;
endpackage

// ===== rtl/usb_charger_detect_protect_ctrl.sv
`timescale 1ns/1ps
module usb_charger_detect_protect_ctrl
  import usb_prot_pkg::*;
#(
  parameter int INT_HOLD_CYC = T_INT_NS / CLK_PERIOD_NS,
  parameter int DET_WAIT_CYC = (T_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  input  wire logic       i_vbus_above_low,
  input  wire logic       i_vbus_above_high,
  input  wire logic       i_dp_se_rx,
  input  wire logic       i_dm_se_rx,
  input  wire logic       i_dm_hi_rx,
  input  wire logic       i_vdat_cmp,
  input  wire logic [1:0] i_addr_lsb,
  input  wire logic       i_cdp_distinguish_enable,
  input  wire logic       i_shorted_high_detect_enable,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe_n,
  output logic            o_int_out,
  output logic            o_int_oe_n,
  output logic            o_pass_switch_closed,
  output logic            o_current_limit_on,
  output logic            o_path_one_on,
  output logic            o_path_two_on,
  output logic [6:0]      o_charger_ctrl
);
  localparam int DW = $clog2(DET_WAIT_CYC + 1);  // Detection timer width
  localparam int IW = $clog2(INT_HOLD_CYC + 1);  // Interrupt timer width

  logic [9:0]  sync1;         // First synchroniser stage
  logic [9:0]  sync2;         // Second synchroniser stage
  logic        scl_d;         // Delayed clock for edges
  logic        sda_d;         // Delayed data for edges
  logic        high_d;        // Delayed over-voltage level
  logic        soft_por;      // One-cycle self reset
  logic        pin_low;       // Constant low drive level
  logic        regs_rst;      // Register reset
  logic        vbus_ok;       // Supply inside window
  logic        vdat_g;        // Gated comparator
  logic        evt;           // Status change event
  logic        host_pass;     // Host enabled pass switch
  logic        next_limit;    // Next current limit state
  det_state_t  det_st;        // Detection state
  logic [2:0]  cls;           // Detected port class
  logic [DW-1:0] det_cnt;     // Detection timer
  logic        done_pulse;    // Detection finished
  logic [7:0]  cfg;           // Configuration register
  logic [7:0]  chg;           // Charger control register
  logic        high_supply_lockout_latch;    // Sticky over-voltage flag
  logic [IW-1:0] int_cnt;     // Interrupt hold timer
  i2c_state_t  i2c_st;        // Bus slave state
  i2c_state_t  nxt;           // State after acknowledge
  logic [3:0]  bit_cnt;       // Bits of current byte
  logic [7:0]  rx_sh;         // Receive shifter
  logic [7:0]  tx_sh;         // Transmit shifter
  logic        rw;            // Read transaction
  logic [3:0]  reg_idx;       // Register index
  logic        wr_stb;        // Register write strobe
  logic [7:0]  wr_data;       // Register write data
  logic        status_rd;     // Status register read

  // Async pin names from synchroniser
  wire vbus_low_s = sync2[0];
  wire vbus_high_s = sync2[1];
  wire dp_s = sync2[2];
  wire dm_s = sync2[3];
  wire dmhi_s = sync2[4];
  wire vdat_s = sync2[5];
  wire scl_s = sync2[6];
  wire sda_s = sync2[7];
  wire [1:0] addr_lsb_s = sync2[9:8];
  wire det_done = (det_st == DET_DONE);
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // Register read decode
  function automatic logic [7:0] reg_read(input logic [3:0] idx);
    case (idx)
      REG_STATUS:   reg_read = {cls, det_done, o_current_limit_on, ~o_pass_switch_closed, high_supply_lockout_latch, ~vbus_high_s};
      REG_CONFIG:   reg_read = cfg;
      REG_CHG_CTRL: reg_read = chg;
      REG_CHG_STAT: reg_read = {4'h0, dmhi_s, dm_s, dp_s, vdat_g};
      default:      reg_read = UNMAPPED_DATA;
    endcase
  endfunction

  // Supply drop or soft reset clears registers
  assign regs_rst = i_rst | ~vbus_low_s | soft_por;
  assign vbus_ok = vbus_low_s & ~vbus_high_s;
  assign vdat_g = vdat_s & ~dp_s & ~dm_s;
  assign evt = done_pulse | (vbus_high_s != high_d);
  assign host_pass = cfg[CFG_OVERRIDE] & cfg[CFG_PASS_EN];

  // Current limit: host override, else dead-battery policy
  always_comb begin
    if (cfg[CFG_CL_OVERRIDE]) begin
      next_limit = vbus_ok & cfg[CFG_CL_EN];
    end else begin
      next_limit = vbus_ok & (~det_done | (cls == CLS_SDP & ~host_pass));
    end
  end

  // Synchronisers and edge history
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1 <= 10'h0;
      sync2 <= 10'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      high_d <= 1'b0;
      pin_low <= 1'b0;
    end else if (i_ce) begin
      sync1 <= {i_addr_lsb, i_sda, i_scl, i_vdat_cmp, i_dm_hi_rx, i_dm_se_rx, i_dp_se_rx, i_vbus_above_high,
                i_vbus_above_low};
      sync2 <= sync1;
      scl_d <= scl_s;
      sda_d <= sda_s;
      high_d <= vbus_high_s;
      pin_low <= 1'b0;
    end
  end

  // Soft reset pulse from configuration write
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      soft_por <= 1'b0;
    end else if (i_ce) begin
      soft_por <= wr_stb & (reg_idx == REG_CONFIG) & wr_data[CFG_SOFT_POR];
    end
  end

  // Automatic charger detection
  always_ff @(posedge i_clk_sys) begin
    if (regs_rst) begin
      det_st <= DET_IDLE;
      cls <= CLS_NONE;
      det_cnt <= '0;
      done_pulse <= 1'b0;
    end else if (i_ce) begin
      done_pulse <= 1'b0;
      case (det_st)
        // Starts on its own once supply valid
        DET_IDLE: begin
          det_cnt <= '0;
          if (vbus_ok) begin
            det_st <= DET_PRIMARY;
          end
        end
        // Source on data line, then classify
        DET_PRIMARY: begin
          if (det_cnt == DW'(DET_WAIT_CYC - 1)) begin
            det_cnt <= '0;
            if (i_shorted_high_detect_enable & dp_s & dm_s) begin
              cls <= dmhi_s ? CLS_SE1_HI : CLS_SE1_LO;
              det_st <= DET_DONE;
              done_pulse <= 1'b1;
            end else if (vdat_g & i_cdp_distinguish_enable) begin
              det_st <= DET_SECONDARY;
            end else begin
              cls <= vdat_g ? CLS_DCP : CLS_SDP;
              det_st <= DET_DONE;
              done_pulse <= 1'b1;
            end
          end else begin
            det_cnt <= det_cnt + 1'b1;
          end
        end
        // Swapped lines separate dedicated from charging host
        DET_SECONDARY: begin
          if (det_cnt == DW'(DET_WAIT_CYC - 1)) begin
            cls <= vdat_g ? CLS_DCP : CLS_CDP;
            det_st <= DET_DONE;
            done_pulse <= 1'b1;
          end else begin
            det_cnt <= det_cnt + 1'b1;
          end
        end
        // Held until supply drop or soft reset
        DET_DONE: det_st <= DET_DONE;
        default: det_st <= DET_IDLE;
      endcase
    end
  end

  // Register file writes and sticky flag
  always_ff @(posedge i_clk_sys) begin
    if (regs_rst) begin
      cfg <= CONFIG_RESET;
      chg <= CHG_CTRL_RESET;
      high_supply_lockout_latch <= 1'b0;
    end else if (i_ce) begin
      if (wr_stb & (reg_idx == REG_CONFIG)) begin
        cfg <= {1'b0, wr_data[6:0]};
      end
      if (wr_stb & (reg_idx == REG_CHG_CTRL)) begin
        chg <= wr_data;
      end
      // Set beats clear on the same cycle
      if (vbus_high_s & ~high_d) begin
        high_supply_lockout_latch <= 1'b1;
      end else if (status_rd) begin
        high_supply_lockout_latch <= 1'b0;
      end
    end
  end

  // Interrupt line timer
  always_ff @(posedge i_clk_sys) begin
    if (regs_rst) begin
      int_cnt <= '0;
      o_int_oe_n <= 1'b1;
    end else if (i_ce) begin
      if (evt) begin
        int_cnt <= IW'(INT_HOLD_CYC);
        o_int_oe_n <= 1'b0;
      end else if (status_rd | (int_cnt == IW'(1))) begin
        int_cnt <= '0;
        o_int_oe_n <= 1'b1;
      end else if (int_cnt != '0) begin
        int_cnt <= int_cnt - 1'b1;
      end
    end
  end

  // Switch, limit, mux and charger circuit drive
  always_ff @(posedge i_clk_sys) begin
    if (regs_rst) begin
      o_pass_switch_closed <= 1'b0;
      o_current_limit_on <= 1'b0;
      o_path_one_on <= 1'b0;
      o_path_two_on <= 1'b0;
      o_charger_ctrl <= 7'h0;
    end else if (i_ce) begin
      o_pass_switch_closed <= vbus_ok & (cfg[CFG_OVERRIDE] ? cfg[CFG_PASS_EN] : (det_done & ~next_limit));
      o_current_limit_on <= next_limit;
      o_path_one_on <= vbus_ok & det_done & cfg[CFG_PATH_ONE];
      o_path_two_on <= vbus_ok & det_done & cfg[CFG_PATH_TWO];
      if (chg[CHG_HOST_CTRL]) begin
        o_charger_ctrl <= chg[6:0];
      end else begin
        o_charger_ctrl <= 7'h0;
        o_charger_ctrl[CHG_SE_RX] <= (det_st == DET_PRIMARY) | (det_st == DET_SECONDARY);
        o_charger_ctrl[CHG_VDAT_SRC] <= (det_st == DET_PRIMARY) | (det_st == DET_SECONDARY);
        o_charger_ctrl[CHG_IDAT_SINK] <= (det_st == DET_PRIMARY) | (det_st == DET_SECONDARY);
        o_charger_ctrl[CHG_HOST_SWAP] <= (det_st == DET_SECONDARY);
      end
    end
  end

  // Bus slave: address, register byte, data
  always_ff @(posedge i_clk_sys) begin
    if (regs_rst) begin
      i2c_st <= I2C_IDLE;
      nxt <= I2C_IDLE;
      bit_cnt <= 4'h0;
      rx_sh <= 8'h0;
      tx_sh <= 8'h0;
      rw <= 1'b0;
      reg_idx <= 4'h0;
      wr_stb <= 1'b0;
      wr_data <= 8'h0;
      status_rd <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else if (i_ce) begin
      wr_stb <= 1'b0;
      status_rd <= 1'b0;
      if (bus_start) begin
        i2c_st <= I2C_DEV;
        bit_cnt <= 4'h0;
        o_sda_oe_n <= 1'b1;
      end else if (bus_stop) begin
        i2c_st <= I2C_IDLE;
        o_sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        // Sample on rising clock
        if (i2c_st == I2C_RACK) begin
          bit_cnt <= 4'h0;
          i2c_st <= sda_s ? I2C_IDLE : I2C_REG;
        end else if (i2c_st != I2C_IDLE && i2c_st != I2C_ACK) begin
          rx_sh <= {rx_sh[6:0], sda_s};
          bit_cnt <= bit_cnt + 1'b1;
        end
      end else if (scl_fall) begin
        // Drive on falling clock
        case (i2c_st)
          I2C_DEV: begin
            if (bit_cnt == 4'h8) begin
              if (rx_sh[7:1] == {DEV_ADDR_HI, addr_lsb_s}) begin
                rw <= rx_sh[0];
                o_sda_oe_n <= 1'b0;
                nxt <= I2C_REG;
                i2c_st <= I2C_ACK;
              end else begin
                i2c_st <= I2C_IDLE;
              end
            end
          end
          I2C_REG: begin
            if (bit_cnt == 4'h8) begin
              reg_idx <= rx_sh[3:0];
              tx_sh <= reg_read(rx_sh[3:0]);
              status_rd <= rw & (rx_sh[3:0] == REG_STATUS);
              o_sda_oe_n <= 1'b0;
              nxt <= rw ? I2C_RDATA : I2C_WDATA;
              i2c_st <= I2C_ACK;
            end
          end
          I2C_WDATA: begin
            if (bit_cnt == 4'h8) begin
              wr_data <= rx_sh;
              wr_stb <= 1'b1;
              o_sda_oe_n <= 1'b0;
              nxt <= I2C_REG;
              i2c_st <= I2C_ACK;
            end
          end
          I2C_ACK: begin
            bit_cnt <= 4'h0;
            i2c_st <= nxt;
            o_sda_oe_n <= (nxt == I2C_RDATA) ? tx_sh[7] : 1'b1;
          end
          I2C_RDATA: begin
            if (bit_cnt == 4'h8) begin
              o_sda_oe_n <= 1'b1;
              i2c_st <= I2C_RACK;
            end else begin
              o_sda_oe_n <= tx_sh[6];
              tx_sh <= {tx_sh[6:0], 1'b0};
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign o_sda_out = pin_low;
  assign o_int_out = pin_low;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_open_outside_window;
    i_ce && !vbus_ok |=> !o_pass_switch_closed;
  endproperty
  a_open_outside_window: assert property (p_open_outside_window) else $error("pass switch closed outside window");

  property p_sdp_limit;
    i_ce && !soft_por && vbus_ok && det_done && cls == CLS_SDP && !host_pass && !cfg[CFG_CL_OVERRIDE]
      |=> o_current_limit_on;
  endproperty
  a_sdp_limit: assert property (p_sdp_limit) else $error("limit released on standard port");

  property p_other_release;
    i_ce && !soft_por && det_done && cls != CLS_SDP && !cfg[CFG_CL_OVERRIDE] |=> !o_current_limit_on;
  endproperty
  a_other_release: assert property (p_other_release) else $error("limit kept after detection");

  property p_done_int;
    i_ce && done_pulse && vbus_low_s && !soft_por |=> !o_int_oe_n && cls != CLS_NONE;
  endproperty
  a_done_int: assert property (p_done_int) else $error("completion not signalled");

  property p_gate;
    vdat_g |-> !dp_s && !dm_s;
  endproperty
  a_gate: assert property (p_gate) else $error("comparator not gated");

  property p_mux_off;
    i_ce && !det_done |=> !o_path_one_on && !o_path_two_on;
  endproperty
  a_mux_off: assert property (p_mux_off) else $error("mux on during detection");

  property p_int_bound;
    int_cnt <= IW'(INT_HOLD_CYC) && (o_int_oe_n == (int_cnt == '0));
  endproperty
  a_int_bound: assert property (p_int_bound) else $error("interrupt timer inconsistent");

  property p_pins_idle;
    i_ce && !vbus_low_s |=> o_sda_oe_n && o_int_oe_n;
  endproperty
  a_pins_idle: assert property (p_pins_idle) else $error("pins driven without supply");

  property p_class_zero;
    !det_done |-> cls == CLS_NONE;
  endproperty
  a_class_zero: assert property (p_class_zero) else $error("class before completion");

  property p_once;
    i_ce && det_done && !regs_rst |=> det_done;
  endproperty
  a_once: assert property (p_once) else $error("detection repeated");
endmodule

// ===== test/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  output logic      o_scl,     // Bus clock, stands high between frames
  output logic      o_sda,     // Data drive, high releases the wire
  input  wire logic i_sda_wire // Resolved data wire
);
  logic [6:0] dev_addr; // Target bus address
  // Idle bus at time zero
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    dev_addr = 7'h00;
  end
  // One bit: data moves while the clock is low, sampled at the rise
  task automatic bit_io(input logic b, output logic r);
    o_scl = 1'b0;
    #10;
    o_sda = b;
    #10;
    o_scl = 1'b1;
    r = i_sda_wire;
    #12;
  endtask
  // Byte MSB first, then the ninth bit; ack is the wire held low
  task automatic byte_io(input logic [7:0] b, input logic nine, output logic [7:0] r, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(nine, n);
    ack = !n;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop_cond();
    o_scl = 1'b0;
    #10;
    o_sda = 1'b0;
    #10;
    o_scl = 1'b1;
    #16;
    o_sda = 1'b1;
    #16;
  endtask
  // Write frame: register and data bytes alternate, stop ends it
  task automatic write_regs(input logic [7:0] q[$], output logic ok);
    logic [7:0] r;
    logic       a;
    o_sda = 1'b0;
    #16;
    byte_io({dev_addr, 1'b0}, 1'b1, r, ok);
    foreach (q[i]) begin
      byte_io(q[i], 1'b1, r, a);
      ok &= a;
    end
    stop_cond();
  endtask
  // Read frame: ack continues with a new register, nack on the last
  task automatic read_regs(input logic [7:0] q[$], output logic [7:0] d[$], output logic ok);
    logic [7:0] r;
    logic       a;
    d = {};
    o_sda = 1'b0;
    #16;
    byte_io({dev_addr, 1'b1}, 1'b1, r, ok);
    foreach (q[i]) begin
      byte_io(q[i], 1'b1, r, a);
      ok &= a;
      byte_io(8'hff, (i == q.size() - 1), r, a);
      d.push_back(r);
    end
    stop_cond();
  endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import usb_prot_pkg::*;
  localparam int INT_HOLD = 600; // Shortened interrupt hold
  localparam int DET_WAIT = 600; // Shortened detection wait
  // Cases {se1, cdp, vdat late, vdat early, dm high, dm, dp}
  localparam logic [6:0] CASES [7] = '{7'h18, 7'h28, 7'h38, 7'h43, 7'h47, 7'h1b, 7'h00};
  logic       clk = 1'b0;            // System clock
  logic       rst = 1'b1;            // Synchronous reset
  logic       vbus_lo, vbus_hi;      // Supply comparators
  logic       dp, dm, dm_hi, vdat;   // Line receivers
  logic       cdp_en, se1_en;        // Detection options
  logic [1:0] addr_lsb;              // Bus address low bits
  logic       scl, sda_m, sda_wire;  // Bus wires
  logic       sda_out, sda_oe_n, int_out, int_oe_n, pass, limit, path_one, path_two;
  logic [6:0] chg;                   // Charger circuit enables
  integer     seed = 68;             // Random seed
  int         errors = 0;
  int         compares = 0;
  int         cycles = 0;
  int         t_high = 0;            // Last cycle the interrupt was seen released
  // Pull-up on data; device pulls low when enabled
  assign sda_wire = sda_m & (sda_oe_n | sda_out);
  always #2 clk = ~clk;
  i2c_master_model u_master (.o_scl(scl), .o_sda(sda_m), .i_sda_wire(sda_wire));
  usb_charger_detect_protect_ctrl #(.INT_HOLD_CYC(INT_HOLD), .DET_WAIT_CYC(DET_WAIT)) uut (
    .i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_vbus_above_low(vbus_lo), .i_vbus_above_high(vbus_hi),
    .i_dp_se_rx(dp), .i_dm_se_rx(dm), .i_dm_hi_rx(dm_hi), .i_vdat_cmp(vdat), .i_addr_lsb(addr_lsb),
    .i_cdp_distinguish_enable(cdp_en), .i_shorted_high_detect_enable(se1_en), .i_scl(scl), .i_sda(sda_wire),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_int_out(int_out), .o_int_oe_n(int_oe_n),
    .o_pass_switch_closed(pass), .o_current_limit_on(limit), .o_path_one_on(path_one),
    .o_path_two_on(path_two), .o_charger_ctrl(chg));
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Hang guard, and last cycle with the interrupt line released
  always @(posedge clk) begin
    cycles++;
    if (int_oe_n !== 1'b0) begin
      t_high = cycles;
    end
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  // Compare on a settled value
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    @(negedge clk);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Wait whole cycles, ending on a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bus frames that must be fully acknowledged
  task automatic wr(input logic [7:0] q[$]);
    logic ok;
    u_master.write_regs(q, ok);
    chk(8'(ok), 8'h01);
  endtask
  task automatic rd(input logic [7:0] q[$], output logic [7:0] d[$]);
    logic ok;
    u_master.read_regs(q, d, ok);
    chk(8'(ok), 8'h01);
  endtask
  // Expected class from line levels and options
  function automatic logic [2:0] exp_class(input logic [6:0] c);
    if (c[6] && c[0] && c[1]) return c[2] ? CLS_SE1_HI : CLS_SE1_LO;
    if (!(c[3] && !c[0] && !c[1])) return CLS_SDP;
    if (c[5] && !c[4]) return CLS_CDP;
    return CLS_DCP;
  endfunction
  // Main sequence
  initial begin
    logic [7:0] d[$];
    logic [6:0] c;
    logic [2:0] cls;
    logic [7:0] r;
    logic       ok;
    int         n;
    {vbus_lo, vbus_hi, dp, dm, dm_hi, vdat, cdp_en, se1_en} = 8'h00;
    addr_lsb = 2'($random(seed));
    cyc(2);
    rst <= 1'b0;
    // Set after time zero so the model's own idle setup cannot overwrite it
    u_master.dev_addr = {DEV_ADDR_HI, addr_lsb};
    for (int k = 0; k < 7; k++) begin
      c = CASES[k];
      cls = exp_class(c);
      vbus_lo <= 1'b0;
      cyc(8);
      chk(8'({sda_out, int_out, sda_oe_n, int_oe_n, path_one, path_two, pass, limit}), 8'h30);
      cyc(1);
      {se1_en, cdp_en, vdat, dm_hi, dm, dp} <= {c[6:5], c[3:0]};
      vbus_lo <= 1'b1;
      cyc(12);
      chk(8'({path_one, path_two, limit}), 8'h01);
      chk(8'(chg), 8'h15);
      rd('{8'h00, 8'h01}, d);
      chk(8'(d[0][7:4]), 8'h00);
      chk(d[1], CONFIG_RESET);
      cyc(300);
      vdat <= c[4];
      n = 0;
      while (int_oe_n !== 1'b0 && n < 2000) begin
        @(posedge clk);
        n++;
      end
      cyc(4);
      chk(8'(int_oe_n), 8'h00);
      chk(8'({path_one, path_two}), 8'h02);
      chk(8'({limit, pass}), (cls == CLS_SDP) ? 8'h02 : 8'h01);
      if (k == 0) begin
        rd('{8'h00}, d);
        cyc(4);
        chk(8'(int_oe_n), 8'h01);
      end else begin
        // Measured from the cycle the line went low, not from the wait loop
        cyc(INT_HOLD - 12 - (cycles - t_high));
        chk(8'(int_oe_n), 8'h00);
        cyc(20);
        chk(8'(int_oe_n), 8'h01);
        rd('{8'h00}, d);
      end
      chk(8'(d[0][7:4]), 8'({cls, 1'b1}));
    end
    cyc(1);
    wr('{8'h01, 8'h05});
    cyc(8);
    chk(8'({pass, limit}), 8'h02);
    u_master.dev_addr[0] = !u_master.dev_addr[0];
    u_master.read_regs('{8'h00}, d, ok);
    chk(8'(ok), 8'h00);
    u_master.dev_addr[0] = !u_master.dev_addr[0];
    rd('{8'h07, 8'h35}, d);
    chk(d[0], UNMAPPED_DATA);
    chk(d[1], UNMAPPED_DATA);
    r = 8'($random(seed)) | 8'h80;
    wr('{8'h12, r, 8'h41, 8'h45});
    cyc(8);
    chk(8'(chg & 7'h1d), 8'(r[6:0] & 7'h1d));
    chk(8'({path_one, path_two, pass}), 8'h03);
    rd('{8'h02, 8'h01}, d);
    chk(d[0], r);
    chk(d[1], 8'h45);
    cyc(1);
    vdat <= 1'b1;
    wr('{8'h03, 8'hff, 8'h00, 8'h1f, 8'h01, 8'h2f});
    rd('{8'h03, 8'h00}, d);
    chk(d[0], 8'h01);
    chk(8'(d[1][7:4]), 8'({CLS_SDP, 1'b1}));
    chk(8'({limit, pass, path_one}), 8'h07);
    cyc(1);
    dp <= 1'b1;
    rd('{8'h03}, d);
    chk(d[0], 8'h02);
    cyc(1);
    vbus_hi <= 1'b1;
    cyc(10);
    chk(8'({pass, path_one, path_two, int_oe_n}), 8'h00);
    // Status during over-voltage: class, done, switch open, latch set
    rd('{8'h00}, d);
    chk(d[0], 8'h76);
    cyc(1);
    vbus_hi <= 1'b0;
    vbus_lo <= 1'b0;
    cyc(10);
    chk(8'({sda_oe_n, int_oe_n, pass, path_two}), 8'h0c);
    cyc(1);
    vbus_lo <= 1'b1;
    cyc(12);
    rd('{8'h01, 8'h02}, d);
    chk(d[0], CONFIG_RESET);
    chk(d[1], CHG_CTRL_RESET);
    tally_and_finish();
  end
endmodule
